// ===== fault_status_registers.sv
// Operation
// - power-stage fault word at offset E0h, 32 bits, read only, zero after reset.
// - bit 31 of the power-stage word is the OR of its fault flags.
// - bit 30 shows a buck regulator fault.
// - bit 28 shows an overcurrent condition.
// - bit 27 reads 0 when a motor supply power-on reset is seen, else 1.
// - bit 26 shows motor supply overvoltage.
// - bit 25 shows thermal warning or thermal shutdown.
// - bit 23 shows a thermal warning.
// - bit 22 shows a thermal shutdown.
// - bits 21 to 16 show per-switch overcurrent, phase C high down to A low.
// - bit 14 shows a one-time programmable memory error.
// - bit 13 shows buck regulator overcurrent.
// - bit 12 shows buck regulator undervoltage.
// - bit 11 shows charge pump undervoltage.
// - algorithm fault word at offset E2h, 32 bits, read only, zero after reset.
// - bit 31 of the algorithm word is the OR of all its flags.
module fault_status_registers
   import fault_status_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // fault detector levels, asynchronous to core_clk
   input wire fault_inputs_t fault_in,
   input wire logic [algorithm_flag_count-1:0] algorithm_flags_in,
   // register access port
   input wire reg_req_t req,
   output reg_rsp_t rsp,
   // summary levels for the fault pin logic
   output logic driver_fault,
   output logic controller_fault
);

   // ********************************************************************
   // state
   // ********************************************************************
   typedef struct packed {
      logic [31:0] power_stage_fault_flags;
      logic [31:0] algorithm_fault_flags;
      reg_rsp_t rsp;
   } bank_state_t;

   bank_state_t state_reg;
   bank_state_t state_next;

   // detector levels after the two flops, and the words built from them
   fault_inputs_t fault_sync_q;
   logic [algorithm_flag_count-1:0] algorithm_sync_q;
   logic [31:0] power_word;
   logic [31:0] algorithm_word;

   // ********************************************************************
   // input synchronisers
   // ********************************************************************
   // detectors sit in the analog domain, so every level crosses two flops
   // a level shorter than one clock may be missed: flags are live, not sticky
   fault_sync #(
      .WIDTH($bits(fault_inputs_t) + algorithm_flag_count)
   ) fault_sync_inst (
      .core_clk(core_clk),
      .nrst(nrst),
      .async_in({fault_in, algorithm_flags_in}),
      .sync_out({fault_sync_q, algorithm_sync_q})
   );

   // ********************************************************************
   // power-stage word assembly
   // ********************************************************************
   // reserved positions start at zero and are never assigned
   // each bit mirrors one detector; only bits 31 and 25 combine levels, and bit 27 is inverted
   always_comb
   begin
      power_word = power_stage_reset;
      power_word[buck_regulator_fault_pos] = fault_sync_q.buck_regulator_fault;
      power_word[overcurrent_any_pos] = fault_sync_q.overcurrent_any;
      // inverted sense: a seen reset reads as 0
      power_word[no_power_on_reset_flag_pos] = ~fault_sync_q.motor_supply_por_seen;
      power_word[supply_overvoltage_pos] = fault_sync_q.supply_overvoltage;
      power_word[thermal_any_pos] = fault_sync_q.thermal_warning
                                    | fault_sync_q.thermal_shutdown;
      power_word[thermal_warning_pos] = fault_sync_q.thermal_warning;
      power_word[thermal_shutdown_pos] = fault_sync_q.thermal_shutdown;
      power_word[switch_overcurrent_hi:switch_overcurrent_lo] = {
         fault_sync_q.overcurrent_high_phase_c,
         fault_sync_q.overcurrent_low_phase_c,
         fault_sync_q.overcurrent_high_phase_b,
         fault_sync_q.overcurrent_low_phase_b,
         fault_sync_q.overcurrent_high_phase_a,
         fault_sync_q.overcurrent_low_phase_a};
      power_word[otp_error_pos] = fault_sync_q.otp_error;
      power_word[buck_overcurrent_pos] = fault_sync_q.buck_overcurrent;
      power_word[buck_undervoltage_pos] = fault_sync_q.buck_undervoltage;
      power_word[charge_pump_undervoltage_pos] = fault_sync_q.charge_pump_undervoltage;
      // summary counts a seen supply reset as a fault, not the inverted flag
      power_word[driver_fault_pos] = fault_sync_q.buck_regulator_fault
                                     | fault_sync_q.overcurrent_any
                                     | fault_sync_q.motor_supply_por_seen
                                     | fault_sync_q.supply_overvoltage
                                     | fault_sync_q.thermal_warning
                                     | fault_sync_q.thermal_shutdown
                                     | (|power_word[switch_overcurrent_hi:switch_overcurrent_lo])
                                     | fault_sync_q.otp_error
                                     | fault_sync_q.buck_overcurrent
                                     | fault_sync_q.buck_undervoltage
                                     | fault_sync_q.charge_pump_undervoltage;
   end

   // ********************************************************************
   // algorithm word assembly
   // ********************************************************************
   // field meanings belong to the controller; this bank only carries them
   // bit 30 stays clear since no flag drives it
   always_comb
   begin
      algorithm_word = algorithm_reset;
      algorithm_word[algorithm_flag_count-1:0] = algorithm_sync_q;
      algorithm_word[controller_fault_pos] = |algorithm_sync_q;
   end

   // ********************************************************************
   // next state and register access
   // ********************************************************************
   // a read returns the word held at the request edge, so the answer is one cycle late
   // every request gets a strobe, mapped or not, so a master never waits
   always_comb
   begin
      state_next = state_reg;
      state_next.power_stage_fault_flags = power_word;
      state_next.algorithm_fault_flags = algorithm_word;
      state_next.rsp.valid = req.valid;
      state_next.rsp.err = 1'b0;
      state_next.rsp.rdata = 32'h0000_0000;
      if (req.valid)
      begin
         case (req.addr)
            power_stage_offset:
            begin
               // writes are accepted and dropped: the word is status only
               if (!req.write)
               begin
                  state_next.rsp.rdata = state_reg.power_stage_fault_flags;
               end
            end
            algorithm_offset:
            begin
               if (!req.write)
               begin
                  state_next.rsp.rdata = state_reg.algorithm_fault_flags;
               end
            end
            default:
            begin
               // unlisted offsets answer with an error and touch nothing
               state_next.rsp.err = 1'b1;
            end
         endcase
      end
   end

   // ********************************************************************
   // state register
   // ********************************************************************
   // both words clear at once; live levels refill them three edges later
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg.power_stage_fault_flags <= power_stage_reset;
         state_reg.algorithm_fault_flags <= algorithm_reset;
         state_reg.rsp <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // outputs come straight from the state flops
   assign rsp = state_reg.rsp;
   assign driver_fault = state_reg.power_stage_fault_flags[driver_fault_pos];
   assign controller_fault = state_reg.algorithm_fault_flags[controller_fault_pos];

   // ********************************************************************
   // assertions
   // ********************************************************************
   default clocking cb @(posedge core_clk);
   endclocking

   default disable iff (!nrst);
   // the words lag the synchronised levels by one edge, hence the past values

   // read of the power-stage word returns the held value one cycle later
   a_power_read_data: assert property (req.valid && !req.write && req.addr == power_stage_offset
      |=> rsp.valid && !rsp.err && rsp.rdata == $past(state_reg.power_stage_fault_flags))
      else $error("power-stage read returned wrong data");

   // summary bit tracks the individual fault bits of the same word
   a_driver_summary: assert property (state_reg.power_stage_fault_flags[driver_fault_pos] ==
      (|(state_reg.power_stage_fault_flags & 32'h54ff_7800)
       | ~state_reg.power_stage_fault_flags[no_power_on_reset_flag_pos])
      || state_reg.power_stage_fault_flags == power_stage_reset)
      else $error("driver summary bit disagrees with fault bits");

   // a buck fault level reaches bit 30 three edges after the pin
   a_buck_latency: assert property (fault_in.buck_regulator_fault [*3]
      |=> state_reg.power_stage_fault_flags[buck_regulator_fault_pos])
      else $error("buck fault not reported within three cycles");

   // overcurrent bit follows the synchronised level
   a_overcurrent_bit: assert property ($past(fault_sync_q.overcurrent_any) ==
      state_reg.power_stage_fault_flags[overcurrent_any_pos])
      else $error("overcurrent bit does not follow detector");

   // supply reset flag is inverted against its detector
   a_por_inverted: assert property (!fault_in.motor_supply_por_seen [*3]
      |=> state_reg.power_stage_fault_flags[no_power_on_reset_flag_pos])
      else $error("power-on reset flag has wrong polarity");

   // overvoltage bit follows the synchronised level
   a_overvoltage_bit: assert property ($past(fault_sync_q.supply_overvoltage) ==
      state_reg.power_stage_fault_flags[supply_overvoltage_pos])
      else $error("overvoltage bit does not follow detector");

   // thermal summary equals warning or shutdown of the same word
   a_thermal_any: assert property (state_reg.power_stage_fault_flags[thermal_any_pos] ==
      (state_reg.power_stage_fault_flags[thermal_warning_pos]
       | state_reg.power_stage_fault_flags[thermal_shutdown_pos]))
      else $error("thermal summary bit wrong");

   // thermal warning and shutdown each follow their own detector
   a_thermal_bits: assert property ({state_reg.power_stage_fault_flags[thermal_warning_pos],
      state_reg.power_stage_fault_flags[thermal_shutdown_pos]}
      == $past({fault_sync_q.thermal_warning, fault_sync_q.thermal_shutdown}))
      else $error("thermal warning or shutdown bit wrong");

   // per-switch field keeps phase C high at the top and phase A low at the bottom
   a_switch_order: assert property ((fault_in.overcurrent_high_phase_c
      && !fault_in.overcurrent_low_phase_a) [*3]
      |=> state_reg.power_stage_fault_flags[switch_overcurrent_hi]
          && !state_reg.power_stage_fault_flags[switch_overcurrent_lo])
      else $error("switch overcurrent bits misplaced");

   // memory and supply rail bits follow their detectors
   a_rail_bits: assert property (
      state_reg.power_stage_fault_flags[otp_error_pos:charge_pump_undervoltage_pos]
      == $past({fault_sync_q.otp_error, fault_sync_q.buck_overcurrent,
                fault_sync_q.buck_undervoltage, fault_sync_q.charge_pump_undervoltage}))
      else $error("memory or rail fault bits wrong");

   // read of the algorithm word returns the held value one cycle later
   a_algorithm_read: assert property (req.valid && !req.write && req.addr == algorithm_offset
      |=> rsp.valid && !rsp.err && rsp.rdata == $past(state_reg.algorithm_fault_flags))
      else $error("algorithm read returned wrong data");

   // controller summary is set exactly when some flag is set
   a_controller_summary: assert property (controller_fault ==
      (|state_reg.algorithm_fault_flags[algorithm_flag_count-1:0]))
      else $error("controller summary bit wrong");

   // reserved bits stay zero and a write returns no data
   a_reserved_zero: assert property (
      (state_reg.power_stage_fault_flags & power_stage_reserved_mask) == 32'h0
      and (req.valid && req.write |=> rsp.rdata == 32'h0))
      else $error("reserved bit or write changed the word");

   // unlisted offsets answer with an error on the next cycle
   a_unmapped_error: assert property (req.valid && req.addr != power_stage_offset
      && req.addr != algorithm_offset |=> rsp.valid && rsp.err)
      else $error("unmapped access not flagged");

   // driver pin follows any synchronised detector one edge later
   a_driver_pin: assert property (driver_fault == $past(fault_sync_q != '0))
      else $error("driver fault pin disagrees with detectors");

   // controller pin follows any synchronised flag one edge later
   a_controller_pin: assert property (controller_fault == $past(algorithm_sync_q != '0))
      else $error("controller fault pin disagrees with flags");

   // flag bits follow their inputs and bit 30 stays clear
   a_algorithm_bits: assert property (state_reg.algorithm_fault_flags[controller_fault_pos-1:0]
      == {1'b0, $past(algorithm_sync_q)})
      else $error("algorithm flag bits wrong");

   // every request, and only a request, gets an answer strobe
   a_answer_strobe: assert property (rsp.valid == $past(req.valid))
      else $error("answer strobe not one cycle after request");

   // an idle cycle leaves the answer group clear
   a_idle_answer: assert property (!req.valid |=> rsp == '0)
      else $error("answer group not clear after idle cycle");

   // a write to a mapped word is answered cleanly with no data
   a_write_answer: assert property (req.valid && req.write
      && (req.addr == power_stage_offset || req.addr == algorithm_offset)
      |=> rsp.valid && !rsp.err && rsp.rdata == 32'h0)
      else $error("write to a status word answered wrongly");

   // a held supply reset clears bit 27
   a_por_detected: assert property (fault_in.motor_supply_por_seen [*3]
      |=> !state_reg.power_stage_fault_flags[no_power_on_reset_flag_pos])
      else $error("power-on reset flag not cleared");

   // a quiet buck detector clears bit 30
   a_buck_clear: assert property (!fault_in.buck_regulator_fault [*3]
      |=> !state_reg.power_stage_fault_flags[buck_regulator_fault_pos])
      else $error("buck fault bit stuck");

   // phase A low lands at the bottom of the switch field
   a_switch_low: assert property ((fault_in.overcurrent_low_phase_a
      && !fault_in.overcurrent_high_phase_c) [*3]
      |=> state_reg.power_stage_fault_flags[switch_overcurrent_lo]
          && !state_reg.power_stage_fault_flags[switch_overcurrent_hi])
      else $error("lowest switch overcurrent bit misplaced");

   // a thermal warning sets its own bit and the thermal summary
   a_warning_bits: assert property (fault_in.thermal_warning [*3]
      |=> state_reg.power_stage_fault_flags[thermal_any_pos]
          && state_reg.power_stage_fault_flags[thermal_warning_pos])
      else $error("thermal warning not reported");

   // a thermal shutdown sets its own bit and the thermal summary
   a_shutdown_bits: assert property (fault_in.thermal_shutdown [*3]
      |=> state_reg.power_stage_fault_flags[thermal_any_pos]
          && state_reg.power_stage_fault_flags[thermal_shutdown_pos])
      else $error("thermal shutdown not reported");

   // ********************************************************************
   // coverage
   // ********************************************************************
   c_power_read: cover property (req.valid && !req.write && req.addr == power_stage_offset
      ##1 rsp.rdata[driver_fault_pos]);
   c_algorithm_read: cover property (req.valid && !req.write && req.addr == algorithm_offset
      ##1 rsp.rdata[controller_fault_pos]);
   c_unmapped: cover property (req.valid && req.addr != power_stage_offset
      && req.addr != algorithm_offset);
   c_both_summaries: cover property (driver_fault && controller_fault);
   c_write_ignored: cover property (req.valid && req.write && req.addr == power_stage_offset
      ##1 rsp.valid && !rsp.err);

endmodule

// ===== fault_status_pkg.sv
package fault_status_pkg;

   // ********************************************************************
   // register map
   // ********************************************************************
   localparam logic [7:0] power_stage_offset = 8'he0;
   localparam logic [7:0] algorithm_offset = 8'he2;
   localparam logic [31:0] power_stage_reset = 32'h0000_0000;
   localparam logic [31:0] algorithm_reset = 32'h0000_0000;

   // ********************************************************************
   // power-stage field positions
   // ********************************************************************
   localparam int driver_fault_pos = 31;
   localparam int buck_regulator_fault_pos = 30;
   localparam int overcurrent_any_pos = 28;
   localparam int no_power_on_reset_flag_pos = 27;
   localparam int supply_overvoltage_pos = 26;
   localparam int thermal_any_pos = 25;
   localparam int thermal_warning_pos = 23;
   localparam int thermal_shutdown_pos = 22;
   localparam int switch_overcurrent_hi = 21;
   localparam int switch_overcurrent_lo = 16;
   localparam int otp_error_pos = 14;
   localparam int buck_overcurrent_pos = 13;
   localparam int buck_undervoltage_pos = 12;
   localparam int charge_pump_undervoltage_pos = 11;
   // bits that always read zero
   localparam logic [31:0] power_stage_reserved_mask = 32'h2100_87ff;

   // ********************************************************************
   // algorithm register field positions
   // ********************************************************************
   localparam int controller_fault_pos = 31;
   localparam int algorithm_flag_count = 30;

   // ********************************************************************
   // carriers
   // ********************************************************************
   // detector levels, all active high; por_seen is high while a motor supply reset is seen
   typedef struct packed {
      logic buck_regulator_fault;
      logic overcurrent_any;
      logic motor_supply_por_seen;
      logic supply_overvoltage;
      logic thermal_warning;
      logic thermal_shutdown;
      logic overcurrent_high_phase_c;
      logic overcurrent_low_phase_c;
      logic overcurrent_high_phase_b;
      logic overcurrent_low_phase_b;
      logic overcurrent_high_phase_a;
      logic overcurrent_low_phase_a;
      logic otp_error;
      logic buck_overcurrent;
      logic buck_undervoltage;
      logic charge_pump_undervoltage;
   } fault_inputs_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic valid;
      logic err;
      logic [31:0] rdata;
   } reg_rsp_t;

endpackage

// ===== fault_sync.sv
module fault_sync
   import fault_status_pkg::*;
#(
   parameter int WIDTH = 46
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // asynchronous detector levels in, synchronised levels out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // ********************************************************************
   // two-stage synchroniser state
   // ********************************************************************
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_state_t;

   sync_state_t state_reg;
   sync_state_t state_next;

   // stage1 is only ever read by stage2, to keep metastability contained
   always_comb
   begin
      state_next = state_reg;
      state_next.stage1 = async_in;
      state_next.stage2 = state_reg.stage1;
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign sync_out = state_reg.stage2;

endmodule

// ===== fault_status_registers_tb.sv
module fault_status_registers_tb
   import fault_status_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ********************************************************************
   // signals and design under test
   // ********************************************************************
   logic core_clk;
   logic nrst;
   fault_inputs_t fault_in;
   logic [algorithm_flag_count-1:0] alg_flags;
   reg_req_t req;
   reg_rsp_t rsp;
   logic driver_fault;
   logic controller_fault;
   int err_total;
   int comparisons;
   // word position of each detector field, lsb field first
   int pos [16] = '{11, 12, 13, 14, 16, 17, 18, 19, 20, 21, 22, 23, 26, 27, 28, 30};

   fault_status_registers fault_status_registers_inst (
      .core_clk(core_clk),
      .nrst(nrst),
      .fault_in(fault_in),
      .algorithm_flags_in(alg_flags),
      .req(req),
      .rsp(rsp),
      .driver_fault(driver_fault),
      .controller_fault(controller_fault)
   );

   // 25 mhz core clock
   always #20 core_clk = ~core_clk;

   // ********************************************************************
   // shared tasks
   // ********************************************************************
   task automatic stop_test();
      if (err_total == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("FAIL %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // one request from a falling edge; answer sampled one cycle later; last drops the strobe
   task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] exp_data,
                         input logic exp_err, input bit last);
      req.valid = 1'b1;
      req.write = wr;
      req.addr = addr;
      req.wdata = 32'hffff_ffff;   // all ones so an ignored write would stand out
      @(posedge core_clk);
      @(negedge core_clk);
      check({31'h0, rsp.valid}, 32'h0000_0001, "response strobe");
      check({31'h0, rsp.err}, {31'h0, exp_err}, "error flag");
      check(rsp.rdata, exp_data, "read data");
      if (last)
         req.valid = 1'b0;
   endtask

   // ********************************************************************
   // scenarios
   // ********************************************************************
   // both words read zero before the detector pipeline fills
   task automatic reset_values();
      check({30'h0, driver_fault, controller_fault}, 32'h0, "summary outputs in reset");
      check({31'h0, rsp.valid}, 32'h0, "strobe in reset");
      nrst = 1'b1;
      access(1'b0, power_stage_offset, 32'h0000_0000, 1'b0, 1'b0);
      access(1'b0, algorithm_offset, 32'h0000_0000, 1'b0, 1'b1);
      cycles(1);
      check({31'h0, rsp.valid}, 32'h0, "strobe after last answer");
   endtask

   // quiet detectors: only the inverted supply flag is set
   task automatic idle_word();
      cycles(6);
      access(1'b0, power_stage_offset, 32'h0800_0000, 1'b0, 1'b1);
      check({31'h0, driver_fault}, 32'h0, "driver summary idle");
   endtask

   // each detector alone lands on its own bit and raises the summary
   task automatic field_walk();
      logic [31:0] e;
      for (int i = 0; i < 16; i++)
      begin
         fault_in = fault_inputs_t'(16'h0001 << i);
         e = 32'h8800_0000;
         e[pos[i]] = (i != 13);
         if (i == 10 || i == 11)
            e[thermal_any_pos] = 1'b1;
         cycles(6);
         access(1'b0, power_stage_offset, e, 1'b0, 1'b1);
         check(rsp.rdata, e, "field word");
         check({31'h0, driver_fault}, 32'h1, "driver summary");
         fault_in = '0;
      end
   endtask

   // every detector at once; reserved bits must stay clear
   task automatic all_faults();
      fault_in = fault_inputs_t'(16'hffff);
      cycles(6);
      access(1'b0, power_stage_offset, 32'hd6ff_7800, 1'b0, 1'b1);
      check(rsp.rdata & power_stage_reserved_mask, 32'h0, "reserved bits");
   endtask

   // writes to both words are answered cleanly; the power-stage word then reads back unchanged
   task automatic write_ignored();
      cycles(1);
      access(1'b1, power_stage_offset, 32'h0000_0000, 1'b0, 1'b0);
      access(1'b1, algorithm_offset, 32'h0000_0000, 1'b0, 1'b0);
      access(1'b0, power_stage_offset, 32'hd6ff_7800, 1'b0, 1'b1);
      fault_in = '0;
   endtask

   // offsets outside the map answer with the error flag, back to back
   task automatic unmapped();
      cycles(1);
      access(1'b0, 8'he1, 32'h0, 1'b1, 1'b0);
      access(1'b0, 8'he4, 32'h0, 1'b1, 1'b0);
      access(1'b0, 8'h00, 32'h0, 1'b1, 1'b0);
      access(1'b0, 8'he3, 32'h0, 1'b1, 1'b1);
   endtask

   // controller flags pass straight through; bit 30 stays clear
   task automatic algorithm_word();
      alg_flags = 30'h2000_0001;
      cycles(6);
      access(1'b0, algorithm_offset, 32'ha000_0001, 1'b0, 1'b1);
      check({31'h0, controller_fault}, 32'h1, "controller summary");
      alg_flags = 30'h0000_0400;
      cycles(6);
      access(1'b0, algorithm_offset, 32'h8000_0400, 1'b0, 1'b0);
      access(1'b0, power_stage_offset, 32'h0800_0000, 1'b0, 1'b1);
      alg_flags = '0;
      cycles(6);
      access(1'b0, algorithm_offset, 32'h0000_0000, 1'b0, 1'b1);
      check({31'h0, controller_fault}, 32'h0, "controller summary clear");
   endtask

   // a second reset mid-run wipes both words even with faults present
   task automatic mid_reset();
      fault_in.thermal_shutdown = 1'b1;
      alg_flags = 30'h0000_0010;
      cycles(6);
      nrst = 1'b0;
      cycles(1);
      check({30'h0, driver_fault, controller_fault}, 32'h0, "summaries in second reset");
      nrst = 1'b1;
      access(1'b0, power_stage_offset, 32'h0000_0000, 1'b0, 1'b1);
      cycles(6);
      access(1'b0, power_stage_offset, 32'h8a40_0000, 1'b0, 1'b0);
      access(1'b0, algorithm_offset, 32'h8000_0010, 1'b0, 1'b1);
      fault_in = '0;
      alg_flags = '0;
   endtask

   // ********************************************************************
   // main sequence and watchdog
   // ********************************************************************
   initial
   begin
      core_clk = 1'b0;
      nrst = 1'b0;
      fault_in = '0;
      alg_flags = '0;
      req = '0;
      err_total = 0;
      comparisons = 0;
      cycles(2);
      reset_values();
      idle_word();
      field_walk();
      all_faults();
      write_ignored();
      unmapped();
      algorithm_word();
      mid_reset();
      cycles(2);
      stop_test();
   end

   // cuts a hung run short; counts as a mismatch
   initial
   begin
      #(40 * 5000);
      err_total++;
      stop_test();
   end
endmodule
